// ---- pkg/psm_pkg.sv ----
// constants and types for the power saving mode sequencer
package psm_pkg;
  localparam logic [7:0] PSM_HALT_OPCODE   = 8'h8e;
  localparam logic [1:0] PSM_PRIO_ALL_EN   = 2'h2;
  localparam int         PSM_DELAY_SHORT   = 256;
  localparam int         PSM_DELAY_LONG    = 4096;
  localparam int         PSM_CNT_W         = 13;
  localparam logic [3:0] PSM_DIV_RST       = 4'h0;
  localparam logic [3:0] PSM_FULL_DIV      = 4'h0;
  typedef enum logic [2:0] {
    PSM_RUN,
    PSM_WAIT,
    PSM_AHALT,
    PSM_HALT,
    PSM_STARTUP
  } psm_state_t;
endpackage

// ---- src/psm_ctrl.sv ----
// power saving mode sequencer: run, slow, wait, active-halt, halt
`timescale 1ns/10ps
`default_nettype none
module psm_ctrl
  import psm_pkg::*;
#(
  parameter int DELAY_SHORT = PSM_DELAY_SHORT,
  parameter int DELAY_LONG  = PSM_DELAY_LONG,
  parameter bit FLASH_PART  = 1'b1
) (
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  input  wire logic       opcode_valid_in,
  input  wire logic [7:0] opcode_in,
  input  wire logic       wfi_in,
  input  wire logic       slow_mode_enable_bit_in,
  input  wire logic [1:0] slow_prescaler_select_in,
  input  wire logic       timebase_interrupt_enable_in,
  input  wire logic       timebase_irq_in,
  input  wire logic       wake_irq_in,
  input  wire logic       ahalt_wake_irq_in,
  input  wire logic       irq_pending_in,
  input  wire logic       watchdog_enable_in,
  input  wire logic       watchdog_stop_option_in,
  input  wire logic       long_delay_option_in,
  input  wire logic [1:0] cc_prio_in,
  output logic            cpu_clk_en_out,
  output logic            periph_clk_en_out,
  output logic            timebase_clk_en_out,
  output logic            osc_enable_out,
  output logic            cc_prio_force_out,
  output logic [1:0]      cc_prio_out,
  output logic            vector_fetch_out,
  output logic            cc_push_out,
  output logic            watchdog_reset_out,
  output logic [2:0]      mode_out
);
  initial begin
    if (DELAY_SHORT < 1 || DELAY_LONG < DELAY_SHORT ||
        DELAY_LONG >= (1 << PSM_CNT_W))
      $error("psm_ctrl: delay parameters out of range");
  end

  localparam logic [PSM_CNT_W-1:0] SHORT_C = PSM_CNT_W'(DELAY_SHORT - 1);
  localparam logic [PSM_CNT_W-1:0] LONG_C  = PSM_CNT_W'(DELAY_LONG - 1);

  psm_state_t            state_q;
  logic [3:0]            div_q;
  logic                  slow_tick;
  logic [PSM_CNT_W-1:0]  dly_q;
  logic                  halt_op;
  logic                  ahalt_wake_int;
  logic                  any_wake;
  logic                  vec_q;
  logic                  push_q;
  logic                  wdg_q;
  logic                  force_q;
  logic                  want_wait;
  logic                  want_halt;
  logic                  wake_go;

  // divide ratio select; 4-bit counter covers the largest ratio of 16
  function automatic logic [3:0] psm_div_mask(input logic [1:0] sel);
    psm_div_mask = 4'((5'h2 << sel) - 5'h1);
  endfunction

  // halt opcode decode
  assign halt_op = opcode_valid_in && (opcode_in == PSM_HALT_OPCODE);
  assign want_wait = opcode_valid_in && wfi_in && !halt_op;
  assign want_halt = halt_op &&
                     !(watchdog_enable_in && !watchdog_stop_option_in &&
                       !timebase_interrupt_enable_in);
  // flash parts accept only the timebase interrupt in active-halt
  assign ahalt_wake_int = timebase_irq_in ||
                          (!FLASH_PART && ahalt_wake_irq_in);
  assign any_wake = wake_irq_in || irq_pending_in;

  // slow clock divider, free running outside halt and startup
  always_ff @(posedge sys_clk_in) begin
    if (reset_in)
      div_q <= PSM_DIV_RST;
    else if (state_q != PSM_HALT && state_q != PSM_STARTUP)
      div_q <= div_q + 4'h1;
  end

  // tick every 2^(sel+1) master cycles when slow mode is on
  assign slow_tick = !slow_mode_enable_bit_in ||
    ((div_q & psm_div_mask(slow_prescaler_select_in)) == PSM_FULL_DIV);

  // main mode sequencer
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_q <= PSM_RUN;
      dly_q   <= '0;
    end else begin
      case (state_q)
        PSM_RUN: begin
          if (want_halt) begin
            // priority forced to 10 means a pending irq wakes halt at once; active-halt on flash parts only wakes on the timebase irq
            if (timebase_interrupt_enable_in)
              state_q <= PSM_AHALT;
            else
              state_q <= PSM_HALT;
          end else if (want_wait) begin
            state_q <= PSM_WAIT;
          end
        end
        PSM_WAIT: begin
          if (any_wake || timebase_irq_in)
            state_q <= PSM_RUN;
        end
        PSM_AHALT: begin
          // no delay on this exit; only the exit from halt counts down through startup
          if (ahalt_wake_int || irq_pending_in && timebase_irq_in)
            state_q <= PSM_RUN;
        end
        PSM_HALT: begin
          if (any_wake) begin
            state_q <= PSM_STARTUP;
            dly_q   <= long_delay_option_in ? LONG_C : SHORT_C;
          end
        end
        PSM_STARTUP: begin
          if (dly_q == '0)
            state_q <= PSM_RUN;
          else
            dly_q <= dly_q - PSM_CNT_W'(1);
        end
        default: state_q <= PSM_RUN;
      endcase
    end
  end

  // one shared wake term keeps vector fetch and cc push in lockstep
  assign wake_go = ((state_q == PSM_WAIT) && (any_wake || timebase_irq_in)) ||
                   ((state_q == PSM_AHALT) && ahalt_wake_int) ||
                   ((state_q == PSM_STARTUP) && (dly_q == '0));

  // vector fetch and cc push pulse on any interrupt wake
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      vec_q  <= 1'b0;
      push_q <= 1'b0;
    end else begin
      vec_q  <= wake_go;
      push_q <= wake_go;
    end
  end

  // watchdog reset instead of halt when option says so
  // never while timebase enable selects active-halt
  always_ff @(posedge sys_clk_in) begin
    if (reset_in)
      wdg_q <= 1'b0;
    else
      wdg_q <= halt_op && watchdog_enable_in && !watchdog_stop_option_in &&
               !timebase_interrupt_enable_in;
  end

  // priority force held in wait, active-halt and halt, released during startup
  always_ff @(posedge sys_clk_in) begin
    if (reset_in)
      force_q <= 1'b0;
    else
      force_q <= (state_q == PSM_RUN) ? (want_halt || want_wait) :
                 (state_q != PSM_STARTUP) && !vec_q;
  end

  // clock gating; wait keeps slow tick on peripherals
  assign cpu_clk_en_out      = (state_q == PSM_RUN) && slow_tick;
  assign periph_clk_en_out   = (state_q == PSM_RUN ||
                                state_q == PSM_WAIT) && slow_tick;
  assign timebase_clk_en_out = (state_q != PSM_HALT &&
                                state_q != PSM_STARTUP);
  assign osc_enable_out      = (state_q != PSM_HALT);
  assign cc_prio_force_out   = force_q;
  assign cc_prio_out         = force_q ? PSM_PRIO_ALL_EN : cc_prio_in;
  assign vector_fetch_out    = vec_q;
  assign cc_push_out         = push_q;
  assign watchdog_reset_out  = wdg_q;
  assign mode_out            = 3'(state_q);

  // halt opcode with timebase enable lands in active-halt
  ahalt_entry_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && want_halt && timebase_interrupt_enable_in)
    |=> state_q == PSM_AHALT)
    else $error("active-halt not entered");
  halt_entry_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && want_halt && !timebase_interrupt_enable_in)
    |=> state_q == PSM_HALT)
    else $error("halt not entered");
  osc_off_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    state_q == PSM_HALT |-> !osc_enable_out && !periph_clk_en_out)
    else $error("oscillator on in halt");
  ahalt_fast_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_AHALT && timebase_irq_in) |=> state_q == PSM_RUN ##0
    vector_fetch_out)
    else $error("active-halt exit delayed");
  sequence halt_wake_s;
    state_q == PSM_HALT && any_wake && !long_delay_option_in;
  endsequence
  startup_delay_a: assert property (@(posedge sys_clk_in)
    disable iff (reset_in)
    halt_wake_s |=> (state_q == PSM_STARTUP && !cpu_clk_en_out)[*8])
    else $error("startup delay cut short");
  prio_force_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && (want_halt || want_wait))
    |=> cc_prio_out == PSM_PRIO_ALL_EN)
    else $error("priority not forced");
  wait_clk_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    state_q == PSM_WAIT |-> !cpu_clk_en_out && periph_clk_en_out == slow_tick)
    else $error("wait clock gating wrong");
  no_wdg_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (halt_op && timebase_interrupt_enable_in) |=> !watchdog_reset_out)
    else $error("watchdog reset in active-halt");
  slow_div_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && slow_mode_enable_bit_in && cpu_clk_en_out &&
     $stable(slow_prescaler_select_in))
    |=> !cpu_clk_en_out || !slow_mode_enable_bit_in)
    else $error("slow divider ticks back to back");

  // sequences shared by the wake-up properties
  sequence wait_wake_s;
    state_q == PSM_WAIT && (any_wake || timebase_irq_in);
  endsequence
  sequence ahalt_wake_s;
    state_q == PSM_AHALT && ahalt_wake_int;
  endsequence
  sequence startup_done_s;
    state_q == PSM_STARTUP && dly_q == '0;
  endsequence
  sequence vector_out_s;
    state_q == PSM_RUN && vector_fetch_out && cc_push_out;
  endsequence

  // wait opcode alone takes run to wait
  wait_entry_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && want_wait && !want_halt)
    |=> state_q == PSM_WAIT)
    else $error("wait not entered");
  // priority stays forced for the whole wait
  wait_force_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    state_q == PSM_WAIT
    |-> cc_prio_force_out && cc_prio_out == PSM_PRIO_ALL_EN)
    else $error("priority not forced in wait");
  // a wake in wait goes straight to the vector
  wait_exit_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    wait_wake_s |=> vector_out_s)
    else $error("wait exit without vector");
  // no wake, no exit from wait
  wait_hold_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_WAIT && !any_wake && !timebase_irq_in)
    |=> state_q == PSM_WAIT)
    else $error("wait left without wake");
  // slow-wait keeps the divided peripheral clock
  slow_wait_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_WAIT && slow_mode_enable_bit_in && periph_clk_en_out &&
     $stable(slow_prescaler_select_in))
    |=> !periph_clk_en_out || !slow_mode_enable_bit_in)
    else $error("slow-wait runs at full rate");
  // interrupt wake from active-halt fetches the vector next cycle
  ahalt_exit_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    ahalt_wake_s |=> vector_out_s)
    else $error("active-halt exit without vector");
  // interrupt exit from active-halt never passes through startup
  ahalt_nodly_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    ahalt_wake_s |=> state_q != PSM_STARTUP)
    else $error("startup delay after active-halt");
  // without an accepted wake, active-halt is kept
  ahalt_flash_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_AHALT && !ahalt_wake_int)
    |=> state_q == PSM_AHALT)
    else $error("active-halt left by a refused wake");
  // only oscillator and timebase run in active-halt
  ahalt_clk_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    state_q == PSM_AHALT
    |-> osc_enable_out && timebase_clk_en_out && !periph_clk_en_out &&
        !cpu_clk_en_out)
    else $error("active-halt clock gating wrong");
  // halt keeps the priority forced so a pending irq wakes it
  halt_prio_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    state_q == PSM_HALT |-> cc_prio_force_out)
    else $error("priority not forced in halt");
  // wake from halt restarts the oscillator but holds the vector
  halt_exit_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_HALT && any_wake)
    |=> state_q == PSM_STARTUP && osc_enable_out && !vector_fetch_out)
    else $error("halt exit wrong");
  // end of startup count hands over to the vector
  startup_end_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    startup_done_s |=> vector_out_s)
    else $error("startup end without vector");
  // any reset lands in run with the oscillator on
  reset_run_a: assert property (
    @(posedge sys_clk_in)
    reset_in |=> state_q == PSM_RUN && osc_enable_out && !vector_fetch_out)
    else $error("reset does not give run");
  // refused halt gives a watchdog reset pulse and stays in run
  wdg_pulse_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && halt_op && watchdog_enable_in &&
     !watchdog_stop_option_in && !timebase_interrupt_enable_in)
    |=> watchdog_reset_out && state_q == PSM_RUN)
    else $error("watchdog halt refusal wrong");
  // any other opcode never reaches a halt state
  opcode_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    (state_q == PSM_RUN && opcode_valid_in &&
     opcode_in != PSM_HALT_OPCODE)
    |=> state_q != PSM_HALT && state_q != PSM_AHALT)
    else $error("halt from a foreign opcode");
  // cc push is a single pulse per wake
  push_pulse_a: assert property (
    @(posedge sys_clk_in) disable iff (reset_in)
    cc_push_out |=> !cc_push_out)
    else $error("cc push longer than one cycle");
endmodule
`default_nettype wire

// ---- tb/psm_irq_model.sv ----
// interrupt source model: request latch cleared on vector fetch
`timescale 1ns/10ps
`default_nettype none
module psm_irq_model (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] req_in,
  input  wire logic       ack_in,
  output logic      [1:0] irq_out
);
  // held until serviced, so a wake that lands early is never lost
  always_ff @(posedge clk_in) begin
    if (reset_in || ack_in)
      irq_out <= 2'h0;
    else
      irq_out <= irq_out | req_in;
  end
endmodule
`default_nettype wire

// ---- tb/psm_ctrl_tb.sv ----
// self-checking bench for the power saving mode sequencer
`timescale 1ns/10ps
`default_nettype none
module psm_ctrl_tb;
  import psm_pkg::*;
  localparam int DS = 10;
  localparam int DL = 20;
  logic clk = 0, rst = 1, opv = 0, wait_for_interrupt_instruction = 0, slow = 0, timebase_interrupt_enable = 0, ahw = 0;
  logic wen = 0, wstop = 0, lng = 0, wseen = 0;
  logic [7:0] op = 8'h00;
  logic [1:0] sel = 2'h0, prio = 2'h0, req = 2'h0, irq, prio_o;
  logic cpu_en, per_en, tb_en, osc, frc, vf, push, wrst;
  logic [2:0] mode;
  int num_errors = 0, cmp_count = 0, seed = 32'h9a25c595, n, c, p;
  logic [15:0] exp_q[$], obs_q[$];
  string nam_q[$];
  event got;
  psm_ctrl #(.DELAY_SHORT(DS), .DELAY_LONG(DL)) psm_ctrl_inst (
    .sys_clk_in(clk), .reset_in(rst), .opcode_valid_in(opv),
    .opcode_in(op), .wfi_in(wait_for_interrupt_instruction), .slow_mode_enable_bit_in(slow),
    .slow_prescaler_select_in(sel), .timebase_interrupt_enable_in(timebase_interrupt_enable),
    .timebase_irq_in(irq[1]), .wake_irq_in(irq[0]),
    .ahalt_wake_irq_in(ahw), .irq_pending_in(|irq),
    .watchdog_enable_in(wen), .watchdog_stop_option_in(wstop),
    .long_delay_option_in(lng), .cc_prio_in(prio),
    .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en),
    .timebase_clk_en_out(tb_en), .osc_enable_out(osc),
    .cc_prio_force_out(frc), .cc_prio_out(prio_o),
    .vector_fetch_out(vf), .cc_push_out(push),
    .watchdog_reset_out(wrst), .mode_out(mode));
  psm_irq_model psm_irq_model_inst (
    .clk_in(clk), .reset_in(rst), .req_in(req), .ack_in(vf),
    .irq_out(irq));
  always #50 clk = ~clk;
  // random core levels; extra wake line is ignored on flash parts
  always @(posedge clk) begin
    prio <= 2'($random(seed));
    ahw <= 1'($random(seed));
    if (wrst)
      wseen <= 1;
  end
  // monitor takes the oldest note for every result
  always @(got) begin
    while (exp_q.size() > 0)
      cmp(nam_q.pop_front(), exp_q.pop_front(), obs_q.pop_front());
  end
  task automatic cmp(input string nm, input logic [15:0] e, v);
    cmp_count++;
    if (v !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic chk(input string nm, input logic [15:0] e, v);
    nam_q.push_back(nm);
    exp_q.push_back(e);
    obs_q.push_back(v);
    -> got;
  endtask
  task automatic issue(input logic [7:0] o, input logic w);
    @(posedge clk);
    opv <= 1;
    op <= o;
    wait_for_interrupt_instruction <= w;
    @(posedge clk);
    opv <= 0;
    wait_for_interrupt_instruction <= 0;
    @(posedge clk) #1;
  endtask
  // raise a request, count cycles until the vector fetch
  task automatic wake(input logic [1:0] r, output int k);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= 2'h0;
    k = 0;
    do begin
      @(posedge clk) #1;
      k++;
    end while (vf !== 1'b1 && k < 300);
  endtask
  task automatic clkcnt(output int a, output int b);
    a = 0;
    b = 0;
    repeat (32) begin
      @(posedge clk) #1;
      a += cpu_en;
      b += per_en;
    end
  endtask
  task automatic results;
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk) #1;
    chk("mode", 16'h0, 16'(mode));
    chk("osc", 16'h1, 16'(osc));
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      slow <= 1;
      sel <= 2'(s);
      @(posedge clk);
      clkcnt(c, p);
      chk("cpu_clk", 16'(32 >> (s + 1)), 16'(c));
    end
    issue(8'h00, 1);
    chk("mode", 16'h1, 16'(mode));
    chk("prio", 16'h2, 16'(prio_o));
    chk("prio_force", 16'h1, 16'(frc));
    clkcnt(c, p);
    chk("cpu_clk", 16'h0, 16'(c));
    chk("per_clk", 16'h2, 16'(p));
    wake(2'h1, n);
    chk("push", 16'h1, 16'(push));
    @(posedge clk) #1;
    chk("mode", 16'h0, 16'(mode));
    slow <= 0;
    issue(8'h8d, 0);
    chk("mode", 16'h0, 16'(mode));
    for (int lo = 0; lo < 2; lo++) begin
      int d;
      d = lo ? DL : DS;
      @(posedge clk);
      lng <= 1'(lo);
      timebase_interrupt_enable <= 1;
      wen <= 1'(lo);
      issue(PSM_HALT_OPCODE, 0);
      chk("mode", 16'h2, 16'(mode));
      chk("prio", 16'h2, 16'(prio_o));
      chk("clk_en", 16'h1, 16'({per_en, tb_en}));
      chk("wdg", 16'h0, 16'(wseen));
      wake(2'h2, n);
      chk("ahalt_exit", 16'h1, 16'(n <= 4));
      // software keeps timebase enable set for the delay
      repeat (d) @(posedge clk);
      timebase_interrupt_enable <= 0;
      wen <= 0;
      req <= 2'h0; // wake source idle and set up before halt
      issue(PSM_HALT_OPCODE, 1);
      chk("mode", 16'h3, 16'(mode));
      chk("osc", 16'h0, 16'(osc));
      wake(2'h1, n);
      chk("startup", 16'h1, 16'(n >= d && n <= d + 5));
    end
    @(posedge clk);
    wen <= 1;
    issue(PSM_HALT_OPCODE, 0);
    chk("wdg", 16'h1, 16'(wseen));
    chk("mode", 16'h0, 16'(mode));
    -> got;
    #1;
    results();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
